// File: logic/pin_mux_pkg.sv
// Package with constants and carrier types for the port override multiplexer.
package pin_mux_pkg;
	localparam int          PORT_WIDTH    = 8;
	localparam logic [7:0]  DIR_RESET     = 8'h00;
	localparam logic [7:0]  OUT_RESET     = 8'h00;
	localparam logic [7:0]  IN_RESET      = 8'h00;
	localparam logic [7:0]  OVR_RESET     = 8'h00;
	localparam logic [2:0]  PULLUP_PATTERN = 3'h2;

	typedef struct packed {
		logic [7:0] pullup_ovr_en;
		logic [7:0] pullup_ovr_val;
		logic [7:0] dir_ovr_en;
		logic [7:0] dir_ovr_val;
		logic [7:0] outval_ovr_en;
		logic [7:0] outval_ovr_val;
		logic [7:0] toggle_ovr_en;
		logic [7:0] inen_ovr_en;
		logic [7:0] inen_ovr_val;
	} ovr_t;

	typedef struct packed {
		logic [7:0] drive_en;
		logic [7:0] drive_val;
		logic [7:0] pullup_en;
		logic [7:0] input_en;
	} pad_ctrl_t;

	typedef enum logic [2:0] {
		MEM_IDLE  = 3'b001,
		MEM_ADDR  = 3'b010,
		MEM_WRITE = 3'b100
	} mem_phase_t;
endpackage

// File: logic/ext_mem_ovr.sv
// Override generator of the external memory interface for the address/data port.
`timescale 1ns/1ps
module ext_mem_ovr (
	input  wire logic                ext_mem_enable,
	input  wire logic                addr_phase_active,
	input  wire logic                write_phase,
	input  wire logic [7:0]          addr_low,
	input  wire logic [7:0]          write_data,
	input  wire logic [7:0]          out_reg_bit,
	input  wire logic                global_pullup_disable,
	output pin_mux_pkg::ovr_t        ovr
);
	import pin_mux_pkg::*;
	logic drive;
	assign drive = write_phase | addr_phase_active;
	always_comb begin
		ovr                = '0;
		ovr.pullup_ovr_en  = {8{ext_mem_enable}};
		ovr.dir_ovr_en     = {8{ext_mem_enable}};
		ovr.outval_ovr_en  = {8{ext_mem_enable}};
		ovr.dir_ovr_val    = {8{drive}};
		ovr.pullup_ovr_val = {8{~drive & ~global_pullup_disable}} & out_reg_bit;
		ovr.outval_ovr_val = ({8{addr_phase_active}} & addr_low)
			| ({8{write_phase}} & write_data);
	end
endmodule

// File: logic/port_pin_override_mux.sv
// Port pin logic with alternate-function overrides and memory-bus mapping.
`timescale 1ns/1ps
module port_pin_override_mux (
	input  wire logic                clk,
	input  wire logic                rst_n,
	input  wire logic [7:0]          dir_wdata,
	input  wire logic                dir_we,
	input  wire logic [7:0]          out_wdata,
	input  wire logic                out_we,
	input  wire logic [7:0]          in_wdata,
	input  wire logic                in_we,
	input  wire logic                global_pullup_disable,
	input  wire logic                sleep,
	input  wire pin_mux_pkg::ovr_t   periph_ovr,
	input  wire logic                ext_mem_enable,
	input  wire logic                addr_phase_active,
	input  wire logic                write_phase,
	input  wire logic [7:0]          addr_low,
	input  wire logic [7:0]          write_data,
	input  wire logic [7:0]          pad_in,
	output logic [7:0]               pad_out,
	output logic [7:0]               pad_oe,
	output logic [7:0]               pad_pullup,
	output logic [7:0]               raw_pin_input,
	output logic [7:0]               mem_read_data,
	output logic [7:0]               dir_bit,
	output logic [7:0]               out_reg_bit,
	output logic [7:0]               in_reg_bit
);
	import pin_mux_pkg::*;

	typedef struct packed {
		logic [7:0] dir;
		logic [7:0] outr;
		logic [7:0] sync1;
		logic [7:0] inr;
		logic [7:0] raw;
		pad_ctrl_t  pad;
	} state_t;

	state_t     q;
	state_t     next_q;
	ovr_t       mem_ovr;
	ovr_t       ovr;
	logic [7:0] gated_in;

	////////////////////////////////////////////////////////////////////////////
	// The memory interface owns the overrides while enabled.
	ext_mem_ovr u_mem (
		.ext_mem_enable        (ext_mem_enable),
		.addr_phase_active     (addr_phase_active),
		.write_phase           (write_phase),
		.addr_low              (addr_low),
		.write_data            (write_data),
		.out_reg_bit           (q.outr),
		.global_pullup_disable (global_pullup_disable),
		.ovr                   (mem_ovr)
	);

	assign ovr = ext_mem_enable ? mem_ovr : periph_ovr;

	////////////////////////////////////////////////////////////////////////////
	// Per-pin next-state logic.
	always_comb begin
		next_q = q;
		if (dir_we) begin
			next_q.dir = dir_wdata;
		end
		if (out_we) begin
			next_q.outr = out_wdata;
		end
		next_q.outr = next_q.outr ^ ({8{in_we}} & in_wdata) ^ ovr.toggle_ovr_en;
		next_q.sync1 = gated_in;
		next_q.inr   = q.sync1;
		next_q.raw   = gated_in;
		for (int i = 0; i < PORT_WIDTH; i++) begin
			next_q.pad.drive_en[i] = ovr.dir_ovr_en[i] ? ovr.dir_ovr_val[i]
				: next_q.dir[i];
			next_q.pad.drive_val[i] = ovr.outval_ovr_en[i] ? ovr.outval_ovr_val[i]
				: next_q.outr[i];
			next_q.pad.pullup_en[i] = ovr.pullup_ovr_en[i] ? ovr.pullup_ovr_val[i]
				: ({next_q.dir[i], next_q.outr[i], global_pullup_disable}
				== PULLUP_PATTERN);
			next_q.pad.input_en[i] = ovr.inen_ovr_en[i] ? ovr.inen_ovr_val[i]
				: ~sleep;
		end
	end

	// Clamp disabled inputs low at the schmitt-trigger stage.
	assign gated_in = pad_in & q.pad.input_en;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q.dir   <= DIR_RESET;
			q.outr  <= OUT_RESET;
			q.sync1 <= IN_RESET;
			q.inr   <= IN_RESET;
			q.raw   <= IN_RESET;
			q.pad   <= {OVR_RESET, OVR_RESET, OVR_RESET, 8'hff};
		end else begin
			q <= next_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs; the analog path is the pad wire itself outside this block.
	assign pad_out       = q.pad.drive_val;
	assign pad_oe        = q.pad.drive_en;
	assign pad_pullup    = q.pad.pullup_en;
	assign raw_pin_input = q.raw;
	assign mem_read_data = q.raw;
	assign dir_bit       = q.dir;
	assign out_reg_bit   = q.outr;
	assign in_reg_bit    = q.inr;
endmodule

// File: sim/periph_ovr_model.sv
// Peripheral model that presents override enables and values to the port.
`timescale 1ns/1ps
module periph_ovr_model (
	input  wire logic [4:0]   en,
	input  wire logic [7:0]   val,
	output pin_mux_pkg::ovr_t ovr
);
	assign ovr = {{8{en[4]}}, val, {8{en[3]}}, val, {8{en[2]}}, val,
		{8{en[1]}}, {8{en[0]}}, val};
endmodule

// File: sim/pin_mux_props.sv
// Checker for the port override multiplexer.
`timescale 1ns/1ps
module pin_mux_props (
	input wire logic              clk,
	input wire logic              rst_n,
	input wire logic              global_pullup_disable,
	input wire pin_mux_pkg::ovr_t periph_ovr,
	input wire logic              ext_mem_enable,
	input wire logic              addr_phase_active,
	input wire logic              write_phase,
	input wire logic [7:0]        addr_low,
	input wire logic [7:0]        write_data,
	input wire logic [7:0]        pad_out,
	input wire logic [7:0]        pad_oe,
	input wire logic [7:0]        pad_pullup,
	input wire logic [7:0]        dir_bit,
	input wire logic [7:0]        out_reg_bit
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_oe;
		$past(ext_mem_enable) |-> pad_oe == {8{$past(write_phase | addr_phase_active)}};
	endproperty
	a_oe: assert property (p_oe) else $error("mem oe");
	property p_ad;
		$past(ext_mem_enable & addr_phase_active & !write_phase) |-> pad_out == $past(addr_low);
	endproperty
	a_ad: assert property (p_ad) else $error("mem addr");
	property p_wd;
		$past(ext_mem_enable & write_phase & !addr_phase_active) |-> pad_out == $past(write_data);
	endproperty
	a_wd: assert property (p_wd) else $error("mem data");
	property p_mp;
		$past(ext_mem_enable) && $stable(out_reg_bit) |-> pad_pullup ==
			($past(write_phase | addr_phase_active | global_pullup_disable) ? 8'h00
			: out_reg_bit);
	endproperty
	a_mp: assert property (p_mp) else $error("mem pullup");
	property p_po;
		$past(!ext_mem_enable && &periph_ovr.pullup_ovr_en)
			|-> pad_pullup == $past(periph_ovr.pullup_ovr_val);
	endproperty
	a_po: assert property (p_po) else $error("pullup ovr");
	property p_do;
		$past(!ext_mem_enable && &periph_ovr.dir_ovr_en)
			|-> pad_oe == $past(periph_ovr.dir_ovr_val);
	endproperty
	a_do: assert property (p_do) else $error("dir ovr");
	property p_vo;
		$past(!ext_mem_enable && &periph_ovr.outval_ovr_en)
			|-> (pad_out & pad_oe) == ($past(periph_ovr.outval_ovr_val) & pad_oe);
	endproperty
	a_vo: assert property (p_vo) else $error("val ovr");
	property p_pn;
		$past(!ext_mem_enable && periph_ovr.pullup_ovr_en == 8'h00)
			&& $stable(dir_bit) && $stable(out_reg_bit) |-> pad_pullup ==
			(~dir_bit & out_reg_bit & {8{!$past(global_pullup_disable)}});
	endproperty
	a_pn: assert property (p_pn) else $error("pullup");
endmodule
bind port_pin_override_mux pin_mux_props i_pin_mux_props (.*);

// File: sim/port_pin_override_mux_tb.sv
// Testbench for the port override multiplexer.
`timescale 1ns/1ps
module port_pin_override_mux_tb;
	import pin_mux_pkg::*;
	logic clk = 0, rst_n = 0, dir_we = 0, out_we = 0, in_we = 0, global_pullup_disable = 0;
	logic sleep = 0, ext_mem_enable = 0, addr_phase_active = 0, write_phase = 0;
	logic [7:0] dir_wdata = 8'h00, out_wdata = 8'h00, in_wdata = 8'h00, addr_low = 8'h00;
	logic [7:0] write_data = 8'h00, pad_in = 8'h5a, val = 8'h00, pad_out, pad_oe, pad_pullup;
	logic [7:0] raw_pin_input, mem_read_data, dir_bit, out_reg_bit, in_reg_bit;
	logic [4:0] en = 5'h00;
	ovr_t periph_ovr;
	int failures = 0, compares = 0, cycles = 0;
	port_pin_override_mux i_port_pin_override_mux (.*);
	periph_ovr_model i_periph_ovr_model (.ovr(periph_ovr), .*);
	initial forever #50 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 400) begin
			failures++;
			close_out();
		end
	end
	task automatic ck(string n, logic [7:0] e, logic [7:0] g);
		compares++;
		if (g !== e) begin
			failures++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic cyc();
		repeat (2) @(posedge clk);
		#1;
	endtask
	task automatic close_out();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1;
		#1 ck("oe", 8'h00, pad_oe);
		ck("pu", 8'h00, pad_pullup);
		@(posedge clk) {dir_wdata, out_wdata, dir_we, out_we} <= {8'h0f, 8'ha5, 2'b11};
		@(posedge clk) {dir_we, out_we} <= 2'b00;
		cyc();
		ck("dir", 8'h0f, dir_bit);
		ck("oe", 8'h0f, pad_oe);
		ck("out", 8'h05, pad_out & pad_oe);
		ck("pu", 8'ha0, pad_pullup);
		@(posedge clk) {in_wdata, in_we} <= {8'h03, 1'b1};
		@(posedge clk) {in_we, en} <= 6'h02;
		@(posedge clk) en <= 5'h00;
		cyc();
		ck("reg", 8'h59, out_reg_bit);
		@(posedge clk) {en, val, sleep} <= {5'h1d, 8'h3c, 1'b1};
		cyc();
		ck("oe", 8'h3c, pad_oe);
		ck("pu", 8'h3c, pad_pullup);
		ck("out", 8'h3c, pad_out & pad_oe);
		ck("raw", 8'h18, raw_pin_input);
		@(posedge clk) en <= 5'h00;
		cyc();
		ck("raw", 8'h00, raw_pin_input);
		@(posedge clk) {sleep, ext_mem_enable, addr_phase_active, addr_low, write_data}
			<= {2'b01, 1'b1, 8'h12, 8'h34};
		cyc();
		ck("oe", 8'hff, pad_oe);
		ck("out", 8'h12, pad_out);
		@(posedge clk) {addr_phase_active, write_phase} <= 2'b01;
		cyc();
		ck("out", 8'h34, pad_out);
		@(posedge clk) write_phase <= 1'b0;
		cyc();
		ck("oe", 8'h00, pad_oe);
		ck("pu", 8'h59, pad_pullup);
		ck("rd", 8'h5a, mem_read_data);
		ck("inr", 8'h5a, in_reg_bit);
		@(posedge clk) global_pullup_disable <= 1'b1;
		cyc();
		ck("pu", 8'h00, pad_pullup);
		close_out();
	end
endmodule
